// ===== core/mdc_pkg.sv
// shared constants and types of the motor drive configuration registers
package mdc_pkg;

    // clock
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned CLK_KHZ = 1000000 / CLK_PERIOD_NS;

    // register indices as printed, byte address is four times the index
    localparam logic [7:0] DRIVE_CFG_INDEX = 8'h95;
    localparam logic [7:0] SENSE_CFG_INDEX = 8'h96;
    localparam logic [11:0] DRIVE_CFG_ADDR = {2'h0, DRIVE_CFG_INDEX, 2'h0};
    localparam logic [11:0] SENSE_CFG_ADDR = {2'h0, SENSE_CFG_INDEX, 2'h0};
    localparam int unsigned ADDR_W = 12;

    // reset values and writable bits
    localparam logic [15:0] DRIVE_CFG_RESET = 16'h0000;
    localparam logic [15:0] SENSE_CFG_RESET = 16'h0000;
    localparam logic [15:0] DRIVE_CFG_WMASK = 16'hffff;
    localparam logic [15:0] SENSE_CFG_WMASK = 16'hff7f;

    // first word field positions
    localparam int unsigned SPEED_SRC_POS = 15;
    localparam int unsigned FREQ_SEL_POS = 14;
    localparam int unsigned KT_THRESH_POS = 12;
    localparam int unsigned SURGE_IND_POS = 11;
    localparam int unsigned SURGE_MECH_POS = 10;
    localparam int unsigned SURGE_TGT_POS = 9;
    localparam int unsigned RELEASE_POS = 8;
    localparam int unsigned CL_DISABLE_POS = 7;
    localparam int unsigned RAMP_POS = 4;
    localparam int unsigned MIN_DUTY_POS = 2;
    localparam int unsigned EDGE_RATE_POS = 0;

    // second word field positions
    localparam int unsigned ADV_ANGLE_POS = 14;
    localparam int unsigned SENSE_THR_POS = 10;
    localparam int unsigned SENSE_CLK_POS = 8;
    localparam int unsigned GAIN_POS = 5;
    localparam int unsigned DEAD_GAP_POS = 0;

    // timing figures
    localparam int unsigned FREQ_LOW_KHZ = 25;
    localparam int unsigned FREQ_HIGH_KHZ = 50;
    localparam logic [12:0] PERIOD_LOW_CYC = 13'(CLK_KHZ / FREQ_LOW_KHZ);
    localparam logic [12:0] PERIOD_HIGH_CYC = 13'(CLK_KHZ / FREQ_HIGH_KHZ);
    localparam int unsigned DEAD_UNIT_NS = 40;
    localparam logic [2:0] DEAD_UNIT_CYC =
        3'((DEAD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // duty figures in per mille
    localparam logic [9:0] DUTY_FLOOR_LOW = 10'd50;
    localparam logic [9:0] DUTY_FLOOR_HIGH = 10'd100;
    localparam logic [9:0] DUTY_HOLD_LIMIT = 10'd15;
    localparam logic [9:0] DUTY_FULL = 10'd1000;

    // answers on the register bus
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic        speed_source_pwm;
        logic        drive_freq_select;
        logic [12:0] drive_period_cyc;
        logic [3:0]  kt_upper_quarters;
        logic [3:0]  kt_lower_quarters;
        logic        surge_inductive_enable;
        logic        surge_mechanical_enable;
        logic        surge_mechanical_target;
        logic        sense_release_hiz;
        logic        closed_loop_disable;
        logic [2:0]  closed_loop_ramp_rate;
        logic        ramp_immediate;
        logic [15:0] ramp_milli_vcc_per_s;
        logic [9:0]  duty_floor_permille;
        logic [9:0]  duty_hold_limit_permille;
        logic [9:0]  duty_below_permille;
        logic [1:0]  phase_edge_rate;
    } mdc_drive_cfg_t;

    typedef struct packed {
        logic [7:0]  sense_advance_deg;
        logic        sense_enable;
        logic [11:0] sense_current_ma;
        logic [6:0]  sense_clock_hz;
        logic [11:0] sense_resolution_ns;
        logic [1:0]  control_gain;
        logic [4:0]  bridge_dead_gap;
        logic [10:0] dead_gap_ns;
        logic [7:0]  dead_gap_cyc;
    } mdc_sense_cfg_t;

endpackage

// ===== core/mdc_cfg_word.sv
// one 16-bit configuration word with byte strobes and a writable mask
`timescale 1ns/1ps
`default_nettype none
module mdc_cfg_word
    import mdc_pkg::*;
#(
    parameter logic [15:0] RESET_VAL = 16'h0000,
    parameter logic [15:0] WMASK     = 16'hffff
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        we,
    input  wire logic [1:0]  strb,
    input  wire logic [15:0] wdata,
    output logic      [15:0] q
);
    logic [15:0] lane_mask;

    assign lane_mask = {{8{strb[1]}}, {8{strb[0]}}} & WMASK;

    // read-only bits keep their reset value whatever is written
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= RESET_VAL;
        end else if (we) begin
            q <= (q & ~lane_mask) | (wdata & lane_mask);
        end
    end
endmodule // mdc_cfg_word
`default_nettype wire

// ===== core/mdc_decode.sv
// turns the two raw words into the values the motor control logic uses
`timescale 1ns/1ps
`default_nettype none
module mdc_decode
    import mdc_pkg::*;
(
    input  wire logic [15:0] drive_word,
    input  wire logic [15:0] sense_word,
    output mdc_drive_cfg_t   drive_cfg,
    output mdc_sense_cfg_t   sense_cfg
);
    function automatic logic [15:0] ramp_rate(input logic [2:0] code);
        unique case (code)
            3'h0: ramp_rate = 16'd0;
            3'h1: ramp_rate = 16'd48000;
            3'h2: ramp_rate = 16'd48000;
            3'h3: ramp_rate = 16'd770;
            3'h4: ramp_rate = 16'd370;
            3'h5: ramp_rate = 16'd190;
            3'h6: ramp_rate = 16'd91;
            3'h7: ramp_rate = 16'd45;
        endcase
    endfunction

    logic [1:0] kt;
    logic [1:0] duty;
    logic [3:0] thr;
    logic [1:0] sclk;
    logic [4:0] gap;

    assign kt   = drive_word[KT_THRESH_POS +: 2];
    assign duty = drive_word[MIN_DUTY_POS +: 2];
    assign thr  = sense_word[SENSE_THR_POS +: 4];
    assign sclk = sense_word[SENSE_CLK_POS +: 2];
    assign gap  = sense_word[DEAD_GAP_POS +: 5];

    always_comb begin
        drive_cfg.speed_source_pwm = drive_word[SPEED_SRC_POS];
        drive_cfg.drive_freq_select = drive_word[FREQ_SEL_POS];
        drive_cfg.drive_period_cyc = drive_word[FREQ_SEL_POS]
            ? PERIOD_HIGH_CYC : PERIOD_LOW_CYC;
        drive_cfg.kt_upper_quarters = kt[0] ? 4'd8 : 4'd6;
        drive_cfg.kt_lower_quarters = kt[1] ? 4'd2 : 4'd3;
        drive_cfg.surge_inductive_enable =
            drive_word[SURGE_IND_POS];
        drive_cfg.surge_mechanical_enable =
            drive_word[SURGE_MECH_POS];
        drive_cfg.surge_mechanical_target =
            drive_word[SURGE_TGT_POS];
        drive_cfg.sense_release_hiz = drive_word[RELEASE_POS];
        drive_cfg.closed_loop_disable =
            drive_word[CL_DISABLE_POS];
        drive_cfg.closed_loop_ramp_rate = drive_word[RAMP_POS +: 3];
        drive_cfg.ramp_immediate =
            (drive_word[RAMP_POS +: 3] == 3'h0);
        drive_cfg.ramp_milli_vcc_per_s =
            ramp_rate(drive_word[RAMP_POS +: 3]);
        drive_cfg.duty_floor_permille =
            duty[0] ? DUTY_FLOOR_HIGH : DUTY_FLOOR_LOW;
        drive_cfg.duty_hold_limit_permille = DUTY_HOLD_LIMIT;
        drive_cfg.duty_below_permille =
            duty[1] ? DUTY_FULL : 10'd0;
        drive_cfg.phase_edge_rate = drive_word[EDGE_RATE_POS +: 2];

        sense_cfg.sense_advance_deg =
            8'(({6'h0, sense_word[ADV_ANGLE_POS +: 2]} + 8'd1) * 8'd30);
        sense_cfg.sense_enable = (thr != 4'h0);
        unique case (thr)
            4'h0: sense_cfg.sense_current_ma = 12'd0;
            4'h1: sense_cfg.sense_current_ma = 12'd400;
            default: sense_cfg.sense_current_ma =
                12'(({8'h0, thr} + 12'd1) * 12'd200);
        endcase
        unique case (sclk)
            2'h0: sense_cfg.sense_clock_hz = 7'd12;
            2'h1: sense_cfg.sense_clock_hz = 7'd24;
            2'h2: sense_cfg.sense_clock_hz = 7'd47;
            2'h3: sense_cfg.sense_clock_hz = 7'd95;
        endcase
        sense_cfg.sense_resolution_ns = 12'(12'd2560 >> sclk);
        sense_cfg.control_gain = sense_word[GAIN_POS +: 2];
        sense_cfg.bridge_dead_gap = gap;
        sense_cfg.dead_gap_ns = 11'(({6'h0, gap} + 11'd1)
            * 11'(DEAD_UNIT_NS));
        sense_cfg.dead_gap_cyc = 8'(({3'h0, gap} + 8'd1)
            * {5'h0, DEAD_UNIT_CYC});
    end
endmodule // mdc_decode
`default_nettype wire

// ===== core/mdc_config_regs.sv
// motor drive configuration words behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module mdc_config_regs
    import mdc_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axil_awaddr,
    input  wire logic [2:0]        s_axil_awprot,
    input  wire logic              s_axil_awvalid,
    output logic                   s_axil_awready,
    input  wire logic [31:0]       s_axil_wdata,
    input  wire logic [3:0]        s_axil_wstrb,
    input  wire logic              s_axil_wvalid,
    output logic                   s_axil_wready,
    output logic [1:0]             s_axil_bresp,
    output logic                   s_axil_bvalid,
    input  wire logic              s_axil_bready,
    input  wire logic [ADDR_W-1:0] s_axil_araddr,
    input  wire logic [2:0]        s_axil_arprot,
    input  wire logic              s_axil_arvalid,
    output logic                   s_axil_arready,
    output logic [31:0]            s_axil_rdata,
    output logic [1:0]             s_axil_rresp,
    output logic                   s_axil_rvalid,
    input  wire logic              s_axil_rready,
    output mdc_drive_cfg_t         drive_cfg,
    output mdc_sense_cfg_t         sense_cfg
);
    // write side holding stations, one per channel
    logic              aw_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic              w_held_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    logic              do_write;
    logic              drive_we;
    logic              sense_we;
    logic              wr_hit;
    logic [1:0]        wr_sel;
    logic [15:0]       drive_word;
    logic [15:0]       sense_word;
    logic              ar_take;
    mdc_drive_cfg_t    drive_cfg_d;
    mdc_sense_cfg_t    sense_cfg_d;

    function automatic logic [1:0] decode_addr(input logic [ADDR_W-1:0] a);
        decode_addr = 2'b00;
        if (a[ADDR_W-1:2] == DRIVE_CFG_ADDR[ADDR_W-1:2]) begin
            decode_addr = 2'b01;
        end else if (a[ADDR_W-1:2] == SENSE_CFG_ADDR[ADDR_W-1:2]) begin
            decode_addr = 2'b10;
        end
    endfunction

    // each station refuses a second item until the response is taken
    assign s_axil_awready = !aw_held_q;
    assign s_axil_wready  = !w_held_q;
    assign s_axil_bvalid  = bvalid_q;
    assign s_axil_bresp   = bresp_q;

    assign wr_sel   = decode_addr(aw_addr_q);
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign drive_we = do_write && wr_sel[0];
    assign sense_we = do_write && wr_sel[1];
    assign wr_hit   = wr_sel != 2'b00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axil_awvalid && !aw_held_q) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axil_awaddr;
        end else if (bvalid_q && s_axil_bready) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axil_wvalid && !w_held_q) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axil_wdata;
            w_strb_q <= s_axil_wstrb;
        end else if (bvalid_q && s_axil_bready) begin
            w_held_q <= 1'b0;
        end
    end

    // an unmapped write is dropped and answered with a slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axil_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    mdc_cfg_word #(
        .RESET_VAL (DRIVE_CFG_RESET),
        .WMASK     (DRIVE_CFG_WMASK)
    ) u_drive_word (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (drive_we),
        .strb    (w_strb_q[1:0]),
        .wdata   (w_data_q[15:0]),
        .q       (drive_word)
    );

    mdc_cfg_word #(
        .RESET_VAL (SENSE_CFG_RESET),
        .WMASK     (SENSE_CFG_WMASK)
    ) u_sense_word (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (sense_we),
        .strb    (w_strb_q[1:0]),
        .wdata   (w_data_q[15:0]),
        .q       (sense_word)
    );

    // read channel: one outstanding read, answer one cycle after the take
    assign ar_take        = s_axil_arvalid && !rvalid_q;
    assign s_axil_arready = !rvalid_q;
    assign s_axil_rvalid  = rvalid_q;
    assign s_axil_rdata   = rdata_q;
    assign s_axil_rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            unique case (decode_addr(s_axil_araddr))
                2'b01: begin
                    rdata_q <= {16'h0000, drive_word};
                    rresp_q <= RESP_OKAY;
                end
                2'b10: begin
                    rdata_q <= {16'h0000, sense_word};
                    rresp_q <= RESP_OKAY;
                end
                default: begin
                    rdata_q <= '0;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (s_axil_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    mdc_decode u_decode (
        .drive_word (drive_word),
        .sense_word (sense_word),
        .drive_cfg  (drive_cfg_d),
        .sense_cfg  (sense_cfg_d)
    );

    // decoded values are registered so the control logic sees clean levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_cfg <= '0;
            sense_cfg <= '0;
        end else begin
            drive_cfg <= drive_cfg_d;
            sense_cfg <= sense_cfg_d;
        end
    end
endmodule // mdc_config_regs
`default_nettype wire

// ===== verification/mdc_config_regs_properties.sv
// checker of bus answers and decoded outputs of the configuration words
`timescale 1ns/1ps
`default_nettype none
module mdc_config_regs_chk
    import mdc_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [ADDR_W-1:0] s_axil_awaddr,
    input wire logic              s_axil_awvalid,
    input wire logic              s_axil_awready,
    input wire logic [31:0]       s_axil_wdata,
    input wire logic [3:0]        s_axil_wstrb,
    input wire logic              s_axil_wvalid,
    input wire logic              s_axil_wready,
    input wire logic [1:0]        s_axil_bresp,
    input wire logic              s_axil_bvalid,
    input wire logic              s_axil_bready,
    input wire logic [ADDR_W-1:0] s_axil_araddr,
    input wire logic              s_axil_arvalid,
    input wire logic              s_axil_arready,
    input wire logic [31:0]       s_axil_rdata,
    input wire logic [1:0]        s_axil_rresp,
    input wire logic              s_axil_rvalid,
    input wire logic              s_axil_rready,
    input wire mdc_drive_cfg_t    drive_cfg,
    input wire mdc_sense_cfg_t    sense_cfg
);
    // captures of the last accepted request, needed no reset: only read
    // after the handshake that loads them
    logic [ADDR_W-1:0] aw_q;
    logic [ADDR_W-1:0] ar_q;
    logic [15:0]       wd_q;
    logic [1:0]        ws_q;

    always_ff @(posedge aclk) begin
        if (s_axil_awvalid && s_axil_awready) aw_q <= s_axil_awaddr;
        if (s_axil_arvalid && s_axil_arready) ar_q <= s_axil_araddr;
        if (s_axil_wvalid && s_axil_wready) begin
            wd_q <= s_axil_wdata[15:0];
            ws_q <= s_axil_wstrb[1:0];
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_both_taken;
        s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
    endsequence
    sequence s_drive_done;
        s_axil_bvalid && s_axil_bready && s_axil_bresp == RESP_OKAY &&
        aw_q == DRIVE_CFG_ADDR && ws_q[0];
    endsequence

    chk_write_answer: assert property (s_both_taken |=>
        !s_axil_bvalid ##1 s_axil_bvalid)
        else $error("write answer not one cycle after store");
    chk_read_answer: assert property (s_axil_arvalid && s_axil_arready |=>
        s_axil_rvalid) else $error("read answer late");
    chk_b_holds: assert property (s_axil_bvalid && !s_axil_bready |=>
        s_axil_bvalid && $stable(s_axil_bresp))
        else $error("write answer dropped before taken");
    chk_r_holds: assert property (s_axil_rvalid && !s_axil_rready |=>
        s_axil_rvalid && $stable(s_axil_rdata) && $stable(s_axil_rresp))
        else $error("read answer changed before taken");
    chk_ar_blocked: assert property (s_axil_rvalid |-> !s_axil_arready)
        else $error("read accepted while answer pending");
    chk_unmapped_err: assert property (s_axil_bvalid &&
        aw_q != DRIVE_CFG_ADDR && aw_q != SENSE_CFG_ADDR |->
        s_axil_bresp == RESP_SLVERR) else $error("unmapped write not refused");
    chk_sense_bit7: assert property (
        s_axil_rvalid && ar_q == SENSE_CFG_ADDR |->
        !s_axil_rdata[7] && s_axil_rdata[31:16] == 16'h0)
        else $error("sense word bit 7 or upper half not zero");
    chk_edge_rate_write: assert property (s_drive_done |=>
        drive_cfg.phase_edge_rate == wd_q[1:0])
        else $error("edge rate not taken from written word");
    chk_freq_decode: assert property ($past(aresetn) |->
        drive_cfg.drive_period_cyc ==
        (drive_cfg.drive_freq_select ? 13'd2000 : 13'd4000))
        else $error("drive period does not match frequency bit");
    chk_dead_gap: assert property ($past(aresetn) |->
        sense_cfg.dead_gap_ns ==
        (11'(sense_cfg.bridge_dead_gap) + 11'h1) * 11'd40)
        else $error("dead gap time wrong");
endmodule // mdc_config_regs_chk

bind mdc_config_regs mdc_config_regs_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata), .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp), .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready), .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready),
    .drive_cfg(drive_cfg), .sense_cfg(sense_cfg)
);
`default_nettype wire

// ===== verification/tb_mdc_config_regs.sv
// self-checking bench of the motor drive configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb_mdc_config_regs
    import mdc_pkg::*;
;
    logic           aclk = 1'b0;
    logic           aresetn = 1'b0;
    logic [11:0]    awaddr = 12'h0;
    logic [11:0]    araddr = 12'h0;
    logic           awvalid = 1'b0;
    logic           wvalid = 1'b0;
    logic           bready = 1'b0;
    logic           arvalid = 1'b0;
    logic           rready = 1'b0;
    logic [31:0]    wdata = 32'h0;
    logic [3:0]     wstrb = 4'h0;
    logic           awready, wready, bvalid, arready, rvalid;
    logic [1:0]     bresp, rresp;
    logic [31:0]    rdata;
    mdc_drive_cfg_t drive_cfg;
    mdc_sense_cfg_t sense_cfg;
    logic [31:0]    seed = 32'd76163;
    logic           slow = 1'b0;
    int             fail_count = 0;
    int             check_count = 0;

    always #5 aclk = ~aclk;

    mdc_config_regs dut (
        .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr),
        .s_axil_awprot(3'h0), .s_axil_awvalid(awvalid),
        .s_axil_awready(awready), .s_axil_wdata(wdata),
        .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
        .s_axil_wready(wready), .s_axil_bresp(bresp),
        .s_axil_bvalid(bvalid), .s_axil_bready(bready),
        .s_axil_araddr(araddr), .s_axil_arprot(3'h0),
        .s_axil_arvalid(arvalid), .s_axil_arready(arready),
        .s_axil_rdata(rdata), .s_axil_rresp(rresp),
        .s_axil_rvalid(rvalid), .s_axil_rready(rready),
        .drive_cfg(drive_cfg), .sense_cfg(sense_cfg)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // an immediate ramp has no rate and disabled sensing no current: zero
    function automatic logic [127:0] exp_drive(input logic [15:0] w);
        mdc_drive_cfg_t e;
        logic [15:0] rt [8] = '{16'd0, 16'd48000, 16'd48000, 16'd770,
                                16'd370, 16'd190, 16'd91, 16'd45};
        e.speed_source_pwm = w[15];
        e.drive_freq_select = w[14];
        e.drive_period_cyc = w[14] ? 13'd2000 : 13'd4000;
        e.kt_upper_quarters = w[12] ? 4'd8 : 4'd6;
        e.kt_lower_quarters = w[13] ? 4'd2 : 4'd3;
        e.surge_inductive_enable = w[11];
        e.surge_mechanical_enable = w[10];
        e.surge_mechanical_target = w[9];
        e.sense_release_hiz = w[8];
        e.closed_loop_disable = w[7];
        e.closed_loop_ramp_rate = w[6:4];
        e.ramp_immediate = w[6:4] == 3'h0;
        e.ramp_milli_vcc_per_s = rt[w[6:4]];
        e.duty_floor_permille = w[2] ? 10'd100 : 10'd50;
        e.duty_hold_limit_permille = 10'd15;
        e.duty_below_permille = w[3] ? 10'd1000 : 10'd0;
        e.phase_edge_rate = w[1:0];
        return 128'(e);
    endfunction

    function automatic logic [127:0] exp_sense(input logic [15:0] w);
        mdc_sense_cfg_t e;
        logic [6:0]  hz [4] = '{7'd12, 7'd24, 7'd47, 7'd95};
        logic [11:0] rs [4] = '{12'd2560, 12'd1280, 12'd640, 12'd320};
        e.sense_advance_deg = 8'(30 * (int'(w[15:14]) + 1));
        e.sense_enable = w[13:10] != 4'h0;
        e.sense_current_ma = (w[13:10] == 4'h0) ? 12'd0 :
            (w[13:10] == 4'h1) ? 12'd400 :
            12'(200 * (int'(w[13:10]) + 1));
        e.sense_clock_hz = hz[w[9:8]];
        e.sense_resolution_ns = rs[w[9:8]];
        e.control_gain = w[6:5];
        e.bridge_dead_gap = w[4:0];
        e.dead_gap_ns = 11'(40 * (int'(w[4:0]) + 1));
        e.dead_gap_cyc = 8'(4 * (int'(w[4:0]) + 1));
        return 128'(e);
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic hang(input string n);
        fail_count++;
        $display("FAIL %s expected answer seen timeout", n);
        finish_test();
    endtask

    task automatic cmp_word(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cmp_cfg(input string n, input logic [127:0] e, g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic axi_write(input logic [11:0] a, input logic [15:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        logic ta = 1'b0;
        logic tw = 1'b0;
        logic tb = 1'b0;
        @(posedge aclk);
        seed = lfsr(seed);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {seed[15:0], d};
        wstrb <= s;
        wvalid <= 1'b1;
        // a slow master lets the answer wait one edge before taking it
        bready <= !slow;
        for (int n = 0; n < 20 && !tb; n++) begin
            #1;
            ta = ta | (awvalid & awready);
            tw = tw | (wvalid & wready);
            tb = bvalid & bready;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            else if (n == 2) bready <= 1'b1;
        end
        if (!tb) hang("write answer");
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        logic ta = 1'b0;
        logic tb = 1'b0;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= !slow;
        for (int n = 0; n < 20 && !tb; n++) begin
            #1;
            ta = ta | (arvalid & arready);
            tb = rvalid & rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tb) rready <= 1'b0;
            else if (n == 2) rready <= 1'b1;
        end
        if (!tb) hang("read answer");
        cmp_word("read data", e, d);
        cmp_word("read resp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic wr_chk(input logic [11:0] a, input logic [15:0] d,
                          input logic [3:0] s, input logic [1:0] er);
        logic [1:0] r;
        axi_write(a, d, s, r);
        cmp_word("write resp", {30'h0, er}, {30'h0, r});
    endtask

    initial begin
        logic [15:0] dw;
        logic [15:0] sw;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(DRIVE_CFG_ADDR, 32'h0, RESP_OKAY);
        rd_chk(SENSE_CFG_ADDR, 32'h0, RESP_OKAY);
        cmp_cfg("drive", exp_drive(16'h0), 128'(drive_cfg));
        cmp_cfg("sense", exp_sense(16'h0), 128'(sense_cfg));
        // neighbours of the two words must be refused
        wr_chk(12'h250, 16'hffff, 4'hf, RESP_SLVERR);
        rd_chk(12'h25c, 32'h0, RESP_SLVERR);
        wr_chk(SENSE_CFG_ADDR, 16'hffff, 4'hf, RESP_OKAY);
        rd_chk(SENSE_CFG_ADDR, 32'h0000ff7f, RESP_OKAY);
        wr_chk(DRIVE_CFG_ADDR, 16'hffff, 4'hf, RESP_OKAY);
        wr_chk(DRIVE_CFG_ADDR, 16'h0, 4'h1, RESP_OKAY);
        rd_chk(DRIVE_CFG_ADDR, 32'h0000ff00, RESP_OKAY);
        // ramp and threshold codes are swept, the other bits random
        for (int i = 0; i < 48; i++) begin
            seed = lfsr(seed);
            slow = seed[7];
            dw = (seed[15:0] & 16'hff8f) | (16'(i % 8) << 4);
            sw = (seed[31:16] & 16'hc3ff) | (16'(i % 16) << 10);
            wr_chk(DRIVE_CFG_ADDR, dw, 4'hf, RESP_OKAY);
            wr_chk(SENSE_CFG_ADDR, sw, 4'hf, RESP_OKAY);
            sw[7] = 1'b0;
            rd_chk(DRIVE_CFG_ADDR, {16'h0, dw}, RESP_OKAY);
            rd_chk(SENSE_CFG_ADDR, {16'h0, sw}, RESP_OKAY);
            cmp_cfg("drive", exp_drive(dw), 128'(drive_cfg));
            cmp_cfg("sense", exp_sense(sw), 128'(sense_cfg));
        end
        slow = 1'b0;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(SENSE_CFG_ADDR, 32'h0, RESP_OKAY);
        rd_chk(DRIVE_CFG_ADDR, 32'h0, RESP_OKAY);
        cmp_cfg("drive", exp_drive(16'h0), 128'(drive_cfg));
        cmp_cfg("sense", exp_sense(16'h0), 128'(sense_cfg));
        finish_test();
    end
endmodule // tb_mdc_config_regs
`default_nettype wire
